/* src/gisa_pkg.sv */
// Purpose: Shared constants for the global interrupt status aggregator.
// Assumes: 5-bit register addresses and 8-bit register data.
// Notes: Offsets, bit positions and reset values live only here.

package gisa_pkg;

    // =========================================================
    // Register map
    localparam int ADDR_W = 5;
    localparam int DATA_W = 8;
    localparam logic [ADDR_W-1:0] GLOBAL_STATUS_OFFSET = 5'h01;
    localparam logic [ADDR_W-1:0] GLOBAL_ENABLE_OFFSET = 5'h02;

    // =========================================================
    // Reset values
    localparam logic [DATA_W-1:0] GLOBAL_STATUS_RESET = 8'h00;
    localparam logic [DATA_W-1:0] GLOBAL_ENABLE_RESET = 8'h00;
    localparam logic [DATA_W-1:0] READ_DATA_RESET = 8'h00;
    localparam logic [DATA_W-1:0] UNMAPPED_READ_VALUE = 8'h00;

    // =========================================================
    // Bit positions of the global status and enable registers
    localparam int WDT_BIT = 7;
    localparam int OVERTEMP_BIT = 6;
    localparam int SUPPLY_BIT = 5;
    localparam int ADC_BIT = 4;
    localparam int HALFBRIDGE_BIT = 3;
    localparam int HIGHSIDE_BIT = 2;
    localparam int MIRROR_BIT = 1;
    localparam int LIN_BIT = 0;

    // =========================================================
    // Positions inside the grouped source flag vectors
    localparam int SUPPLY_OV_POS = 0;
    localparam int SUPPLY_UV_POS = 1;
    localparam int SUPPLY_CP_POS = 2;
    localparam int ADC_READY_POS = 0;
    localparam int ADC_CMP_POS = 1;
    localparam int LIN_WAKE_POS = 0;
    localparam int LIN_DTO_POS = 1;
    localparam int LIN_SHORT_POS = 2;

    // Default driver counts
    localparam int NUM_HALFBRIDGE = 4;
    localparam int NUM_HIGHSIDE = 4;

endpackage

/* src/gisa_flag_cell.sv */
// Purpose: Sticky event flags cleared by a write-one request.
// Assumes: Events and clear requests are on the same clock.
// Notes: An event present in the clear cycle keeps the flag set.

`timescale 1ns/100ps

module gisa_flag_cell #(
    parameter int WIDTH = 1
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] set_evt,
    input wire logic [WIDTH-1:0] clr_req,
    output logic [WIDTH-1:0] flags
);

    logic [WIDTH-1:0] flag_reg;
    logic [WIDTH-1:0] flag_next;

    // =========================================================
    // Flag storage
    // Set wins over clear, so a live cause is never lost
    always_comb begin
        flag_next = (flag_reg & ~clr_req) | set_evt;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            flag_reg <= '0;
        end else begin
            flag_reg <= flag_next;
        end
    end

    assign flags = flag_reg;

endmodule

/* src/gisa_aggregator.sv */
// Purpose: Global interrupt status and enable registers with source flags.
// Assumes: Register strobes come from the serial link slave, same clock.
// Notes: Status reads back one cycle after the read strobe.
// Function
// - Watchdog bit set on timeout in standby only, otherwise stays clear.
// - Watchdog bit clears only when its clear control bit toggles.
// - Over-temperature bit set on event, cleared via its source flag.
// - Supply bit set when over-voltage or under-voltage flag is set.
// - Supply bit ignores direct clear; clears once all three flags clear.
// - Converter bit set on conversion ready or comparator hit.
// - Converter bit not directly clearable; clears with both source flags.
// - Half-bridge bit is OR of per-driver over-current flags.
// - Half-bridge bit ignores direct clear; clears when all flags clear.
// - High-side bit is OR of per-driver over-current flags.
// - High-side bit ignores direct clear; clears when all flags clear.
// - Mirror bit is no storage; it mirrors the diagnostic flag.
// - Mirror over-current disables the mirror driver and sets its flag.
// - Mirror flag and bit cleared through the diagnostic register.
// - LIN bit set on wake-up, dominant timeout or bus short.
// - LIN bit ignores direct clear; clears once all three flags clear.
// - Events set flags whatever the enable bits hold.
// - Writing one to a flag requests a clear; value is not stored.
// - A clear request while the cause persists leaves the flag set.
// - Separate read/write enable register, one bit per status bit.

`timescale 1ns/100ps

module gisa_aggregator
    import gisa_pkg::*;
#(
    parameter int NUM_HB = NUM_HALFBRIDGE,
    parameter int NUM_HS = NUM_HIGHSIDE
) (
    input wire logic clk,
    input wire logic rst_n,
    // Register access from the link slave
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata,
    output logic [DATA_W-1:0] reg_rdata,
    // Watchdog
    input wire logic watchdog_timeout,
    input wire logic standby_mode,
    input wire logic watchdog_clear_bit,
    // Over-temperature
    input wire logic overtemp_evt,
    input wire logic overtemp_clr,
    // Supply: over-voltage, under-voltage, charge-pump error
    input wire logic [2:0] supply_evt,
    input wire logic [2:0] supply_clr,
    // Converter: ready, comparator hit
    input wire logic [1:0] adc_evt,
    input wire logic [1:0] adc_clr,
    // Driver over-currents
    input wire logic [NUM_HB-1:0] halfbridge_oc_evt,
    input wire logic [NUM_HB-1:0] halfbridge_oc_clr,
    input wire logic [NUM_HS-1:0] highside_oc_evt,
    input wire logic [NUM_HS-1:0] highside_oc_clr,
    input wire logic mirror_oc_evt,
    input wire logic mirror_oc_clr,
    // LIN: wake-up, dominant timeout, short
    input wire logic [2:0] lin_evt,
    input wire logic [2:0] lin_clr,
    // Source flags for the peripheral status registers
    output logic watchdog_timeout_flag,
    output logic overtemp_source_flag,
    output logic [2:0] supply_flags,
    output logic [1:0] adc_flags,
    output logic [NUM_HB-1:0] halfbridge_overcurrent_per_driver,
    output logic [NUM_HS-1:0] highside_overcurrent_per_driver,
    output logic mirror_driver_overcurrent_flag,
    output logic mirror_driver_disable,
    output logic [2:0] lin_flags,
    // Summary and request
    output logic [DATA_W-1:0] global_interrupt_status,
    output logic irq
);

    // =========================================================
    // Declarations
    logic wdt_flag_reg;
    logic wdt_clr_prev_reg;
    logic wdt_toggle;
    logic supply_sum_reg;
    logic [DATA_W-1:0] enable_reg;
    logic [DATA_W-1:0] rdata_reg;
    logic [DATA_W-1:0] rdata_next;
    logic irq_reg;
    logic [DATA_W-1:0] status;
    logic [DATA_W-1:0] raised;

    // =========================================================
    // Source flag cells
    // Write-one clear requests arrive as pulses; value never stored
    gisa_flag_cell #(.WIDTH(1)) u_overtemp (
        .clk(clk),
        .rst_n(rst_n),
        .set_evt(overtemp_evt),
        .clr_req(overtemp_clr),
        .flags(overtemp_source_flag)
    );

    gisa_flag_cell #(.WIDTH(3)) u_supply (
        .clk(clk),
        .rst_n(rst_n),
        .set_evt(supply_evt),
        .clr_req(supply_clr),
        .flags(supply_flags)
    );

    gisa_flag_cell #(.WIDTH(2)) u_adc (
        .clk(clk),
        .rst_n(rst_n),
        .set_evt(adc_evt),
        .clr_req(adc_clr),
        .flags(adc_flags)
    );

    gisa_flag_cell #(.WIDTH(NUM_HB)) u_halfbridge (
        .clk(clk),
        .rst_n(rst_n),
        .set_evt(halfbridge_oc_evt),
        .clr_req(halfbridge_oc_clr),
        .flags(halfbridge_overcurrent_per_driver)
    );

    gisa_flag_cell #(.WIDTH(NUM_HS)) u_highside (
        .clk(clk),
        .rst_n(rst_n),
        .set_evt(highside_oc_evt),
        .clr_req(highside_oc_clr),
        .flags(highside_overcurrent_per_driver)
    );

    gisa_flag_cell #(.WIDTH(1)) u_mirror (
        .clk(clk),
        .rst_n(rst_n),
        .set_evt(mirror_oc_evt),
        .clr_req(mirror_oc_clr),
        .flags(mirror_driver_overcurrent_flag)
    );

    gisa_flag_cell #(.WIDTH(3)) u_lin (
        .clk(clk),
        .rst_n(rst_n),
        .set_evt(lin_evt),
        .clr_req(lin_clr),
        .flags(lin_flags)
    );

    // Driver stays off until software clears the flag
    assign mirror_driver_disable = mirror_driver_overcurrent_flag;

    // =========================================================
    // Watchdog flag
    assign wdt_toggle = watchdog_clear_bit ^ wdt_clr_prev_reg;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wdt_clr_prev_reg <= 1'b0;
        end else begin
            wdt_clr_prev_reg <= watchdog_clear_bit;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wdt_flag_reg <= 1'b0;
        end else if (watchdog_timeout && standby_mode) begin
            wdt_flag_reg <= 1'b1;
        end else if (wdt_toggle) begin
            wdt_flag_reg <= 1'b0;
        end
    end

    assign watchdog_timeout_flag = wdt_flag_reg;

    // =========================================================
    // Supply summary
    // Set by voltage flags only; the charge-pump flag merely holds it
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            supply_sum_reg <= 1'b0;
        end else if (supply_flags[SUPPLY_OV_POS] || supply_flags[SUPPLY_UV_POS]) begin
            supply_sum_reg <= 1'b1;
        end else if (supply_flags == 3'h0) begin
            supply_sum_reg <= 1'b0;
        end
    end

    // =========================================================
    // Global status assembly
    always_comb begin
        status = GLOBAL_STATUS_RESET;
        status[WDT_BIT] = wdt_flag_reg;
        status[OVERTEMP_BIT] = overtemp_source_flag;
        status[SUPPLY_BIT] = supply_sum_reg;
        status[ADC_BIT] = |adc_flags;
        status[HALFBRIDGE_BIT] = |halfbridge_overcurrent_per_driver;
        status[HIGHSIDE_BIT] = |highside_overcurrent_per_driver;
        status[MIRROR_BIT] = mirror_driver_overcurrent_flag;
        status[LIN_BIT] = |lin_flags;
    end

    assign global_interrupt_status = status;

    // =========================================================
    // Enable register
    // Status is read-only: writes to it fall through untouched
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            enable_reg <= GLOBAL_ENABLE_RESET;
        end else if (reg_wr && reg_addr == GLOBAL_ENABLE_OFFSET) begin
            enable_reg <= reg_wdata;
        end
    end

    // =========================================================
    // Read port
    always_comb begin
        case (reg_addr)
            GLOBAL_STATUS_OFFSET: begin
                rdata_next = status;
            end
            GLOBAL_ENABLE_OFFSET: begin
                rdata_next = enable_reg;
            end
            default: begin
                rdata_next = UNMAPPED_READ_VALUE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_reg <= READ_DATA_RESET;
        end else if (reg_rd) begin
            rdata_reg <= rdata_next;
        end
    end

    assign reg_rdata = rdata_reg;

    // =========================================================
    // Interrupt request
    // Registered so the request line is glitch free
    assign raised = status & enable_reg;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_reg <= 1'b0;
        end else begin
            irq_reg <= |raised;
        end
    end

    assign irq = irq_reg;

    // =========================================================
    // Checks
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    wdt_standby_set_a: assert property (
        (watchdog_timeout && standby_mode) |=> global_interrupt_status[WDT_BIT]
    ) else $error("watchdog bit not set on standby timeout");

    wdt_rise_cause_a: assert property (
        $rose(global_interrupt_status[WDT_BIT])
            |-> $past(watchdog_timeout && standby_mode)
    ) else $error("watchdog bit set outside standby timeout");

    wdt_clear_toggle_a: assert property (
        $fell(global_interrupt_status[WDT_BIT])
            |-> $past(watchdog_clear_bit) != $past(watchdog_clear_bit, 2)
    ) else $error("watchdog bit cleared without clear toggle");

    overtemp_set_a: assert property (
        overtemp_evt |=> global_interrupt_status[OVERTEMP_BIT]
    ) else $error("overtemp bit not set on event");

    supply_set_a: assert property (
        (supply_evt[SUPPLY_OV_POS] || supply_evt[SUPPLY_UV_POS])
            |=> ##1 global_interrupt_status[SUPPLY_BIT]
    ) else $error("supply bit not set after voltage event");

    supply_hold_a: assert property (
        $fell(global_interrupt_status[SUPPLY_BIT]) |-> $past(supply_flags) == 3'h0
    ) else $error("supply bit cleared while a source flag was set");

    adc_set_a: assert property (
        (|adc_evt) |=> global_interrupt_status[ADC_BIT]
    ) else $error("converter bit not set on event");

    hb_direct_clear_a: assert property (
        (global_interrupt_status[HALFBRIDGE_BIT] && halfbridge_oc_clr == '0
            && reg_wr && reg_addr == GLOBAL_STATUS_OFFSET)
            |=> global_interrupt_status[HALFBRIDGE_BIT]
    ) else $error("half-bridge bit cleared by a direct write");

    hs_no_enable_a: assert property (
        (highside_oc_evt[0] && !enable_reg[HIGHSIDE_BIT]
            && !(|(global_interrupt_status & enable_reg)))
            |=> global_interrupt_status[HIGHSIDE_BIT] && !irq
    ) else $error("high-side event lost or request raised while disabled");

    mirror_disable_a: assert property (
        mirror_oc_evt |=> mirror_driver_disable && global_interrupt_status[MIRROR_BIT]
    ) else $error("mirror over-current did not disable driver");

    clear_pending_a: assert property (
        (lin_evt[LIN_DTO_POS] && lin_clr[LIN_DTO_POS])
            |=> lin_flags[LIN_DTO_POS] && global_interrupt_status[LIN_BIT]
    ) else $error("flag cleared while its cause persisted");

    lin_clear_a: assert property (
        (lin_flags != 3'h0 && (lin_flags & ~lin_clr) == 3'h0 && lin_evt == 3'h0)
            |=> !global_interrupt_status[LIN_BIT]
    ) else $error("LIN bit did not clear after write-one clears");

    enable_write_a: assert property (
        (reg_wr && reg_addr == GLOBAL_ENABLE_OFFSET)
            ##1 (reg_rd && reg_addr == GLOBAL_ENABLE_OFFSET && !reg_wr)
            |=> reg_rdata == $past(reg_wdata, 2)
    ) else $error("enable register did not read back its write");

    irq_follow_a: assert property (
        (|(global_interrupt_status & enable_reg)) |=> irq
    ) else $error("request missing with an enabled status bit");

    irq_cause_a: assert property (
        irq |-> $past(|(global_interrupt_status & enable_reg))
    ) else $error("request raised with no enabled status bit");

    hs_hold_a: assert property (
        (global_interrupt_status[HIGHSIDE_BIT] && highside_oc_clr == '0)
            |=> global_interrupt_status[HIGHSIDE_BIT]
    ) else $error("high-side bit cleared with no flag clear");

    read_hold_a: assert property (
        !reg_rd |=> $stable(reg_rdata)
    ) else $error("read data changed without a read request");

endmodule

/* tb/gisa_mcu_model.sv */
// Purpose: Controller-side model that issues register strobes to the aggregator.
// Assumes: Called from the bench at a falling edge; one request per call, except wr_rd, which issues a write then a read.
// Notes: Address and data are inverted once released so stale values never match.

`timescale 1ns/100ps

module gisa_mcu_model
    import gisa_pkg::*;
(
    input wire logic clk,
    output logic reg_wr,
    output logic reg_rd,
    output logic [ADDR_W-1:0] reg_addr,
    output logic [DATA_W-1:0] reg_wdata,
    input wire logic [DATA_W-1:0] reg_rdata
);
    initial begin
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = '0;
        reg_wdata = '0;
    end

    // =========================================================
    // Write commit, one cycle; extra leading edge keeps calls back to back safe
    task automatic wr(logic [ADDR_W-1:0] a, logic [DATA_W-1:0] d);
        @(negedge clk);
        reg_wr = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        @(negedge clk);
        reg_wr = 1'b0;
        reg_addr = ~a;
        reg_wdata = ~d;
    endtask

    // =========================================================
    // Read request; data is settled by the following falling edge
    task automatic rd(logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
        @(negedge clk);
        reg_rd = 1'b1;
        reg_addr = a;
        @(negedge clk);
        reg_rd = 1'b0;
        reg_addr = ~a;
        d = reg_rdata;
    endtask

    // =========================================================
    // Write then read of one address on consecutive edges
    task automatic wr_rd(logic [ADDR_W-1:0] a, logic [DATA_W-1:0] w, output logic [DATA_W-1:0] d);
        @(negedge clk);
        reg_wr = 1'b1;
        reg_addr = a;
        reg_wdata = w;
        @(negedge clk);
        reg_wr = 1'b0;
        reg_rd = 1'b1;
        @(negedge clk);
        reg_rd = 1'b0;
        reg_addr = ~a;
        reg_wdata = ~w;
        d = reg_rdata;
    endtask
endmodule

/* tb/gisa_aggregator_tb.sv */
// Purpose: Self-checking bench for the global interrupt status aggregator.
// Assumes: Inputs change on the falling clock edge only.
// Notes: Every scenario ends on a falling edge.

`timescale 1ns/100ps

module gisa_aggregator_tb
    import gisa_pkg::*;
;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic watchdog_timeout = 1'b0, standby_mode = 1'b0, watchdog_clear_bit = 1'b0;
    logic overtemp_evt = 1'b0, overtemp_clr = 1'b0, mirror_oc_evt = 1'b0, mirror_oc_clr = 1'b0;
    logic [2:0] supply_evt = '0, supply_clr = '0, lin_evt = '0, lin_clr = '0;
    logic [1:0] adc_evt = '0, adc_clr = '0;
    logic [3:0] halfbridge_oc_evt = '0, halfbridge_oc_clr = '0;
    logic [3:0] highside_oc_evt = '0, highside_oc_clr = '0;
    logic reg_wr, reg_rd, irq, mirror_driver_disable;
    logic watchdog_timeout_flag, overtemp_source_flag, mirror_driver_overcurrent_flag;
    logic [2:0] supply_flags, lin_flags;
    logic [1:0] adc_flags;
    logic [3:0] halfbridge_overcurrent_per_driver, highside_overcurrent_per_driver;
    logic [ADDR_W-1:0] reg_addr;
    logic [DATA_W-1:0] reg_wdata, reg_rdata, global_interrupt_status, d;
    int fails = 0;
    int total_checks = 0;
    int widths[7] = '{3, 1, 4, 4, 2, 2, 1};

    gisa_aggregator DUT (.clk, .rst_n, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata,
        .watchdog_timeout, .standby_mode, .watchdog_clear_bit, .overtemp_evt, .overtemp_clr,
        .supply_evt, .supply_clr, .adc_evt, .adc_clr, .halfbridge_oc_evt, .halfbridge_oc_clr,
        .highside_oc_evt, .highside_oc_clr, .mirror_oc_evt, .mirror_oc_clr, .lin_evt, .lin_clr,
        .watchdog_timeout_flag, .overtemp_source_flag, .supply_flags, .adc_flags,
        .halfbridge_overcurrent_per_driver, .highside_overcurrent_per_driver,
        .mirror_driver_overcurrent_flag, .mirror_driver_disable, .lin_flags,
        .global_interrupt_status, .irq);

    gisa_mcu_model mcu (.clk, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata);

    initial begin
        forever #25 clk = ~clk;
    end

    // =========================================================
    // Shared helpers
    task automatic chk(string n, logic [7:0] e, logic [7:0] g);
        total_checks++;
        if (g !== e) begin
            $display("ERROR %s expected %h seen %h", n, e, g);
            fails++;
        end
    endtask

    task automatic cyc(int n);
        repeat (n) @(negedge clk);
    endtask

    // Status bit index selects the source group
    task automatic drive(int b, logic [3:0] e, logic [3:0] c);
        case (b)
            0: begin
                lin_evt = e[2:0];
                lin_clr = c[2:0];
            end
            1: begin
                mirror_oc_evt = e[0];
                mirror_oc_clr = c[0];
            end
            2: begin
                highside_oc_evt = e;
                highside_oc_clr = c;
            end
            3: begin
                halfbridge_oc_evt = e;
                halfbridge_oc_clr = c;
            end
            4: begin
                adc_evt = e[1:0];
                adc_clr = c[1:0];
            end
            5: begin
                supply_evt = e[2:0];
                supply_clr = c[2:0];
            end
            default: begin
                overtemp_evt = e[0];
                overtemp_clr = c[0];
            end
        endcase
    endtask

    // Source flags of the group behind one status bit
    function automatic logic [7:0] src_flags(int b);
        case (b)
            0: return {5'h0, lin_flags};
            1: return {7'h0, mirror_driver_overcurrent_flag};
            2: return {4'h0, highside_overcurrent_per_driver};
            3: return {4'h0, halfbridge_overcurrent_per_driver};
            4: return {6'h0, adc_flags};
            5: return {5'h0, supply_flags};
            default: return {7'h0, overtemp_source_flag};
        endcase
    endfunction

    // One-cycle event or clear; two cycles covers the slower supply bit
    task automatic pulse(int b, logic [3:0] e, logic [3:0] c);
        drive(b, e, c);
        cyc(1);
        drive(b, 4'h0, 4'h0);
        cyc(2);
    endtask

    // =========================================================
    // Scenarios
    task automatic reset_regs;
        chk("rdata reset", READ_DATA_RESET, reg_rdata);
        mcu.rd(GLOBAL_STATUS_OFFSET, d);
        chk("status reset", GLOBAL_STATUS_RESET, d);
        mcu.wr(GLOBAL_STATUS_OFFSET, 8'hFF);
        mcu.wr(5'h1F, 8'hFF);
        mcu.rd(GLOBAL_ENABLE_OFFSET, d);
        chk("enable reset", GLOBAL_ENABLE_RESET, d);
        mcu.rd(5'h1F, d);
        chk("unmapped", UNMAPPED_READ_VALUE, d);
        mcu.wr(GLOBAL_ENABLE_OFFSET, 8'hA5);
        mcu.rd(GLOBAL_ENABLE_OFFSET, d);
        chk("enable rw", 8'hA5, d);
        mcu.wr_rd(GLOBAL_ENABLE_OFFSET, 8'h5A, d);
        chk("enable back to back", 8'h5A, d);
        mcu.rd(GLOBAL_STATUS_OFFSET, d);
        chk("status ro", 8'h00, d);
    endtask

    task automatic one_source(int b, logic [3:0] e);
        mcu.wr(GLOBAL_ENABLE_OFFSET, 8'h00);
        pulse(b, e, 4'h0);
        chk("status set", 8'h01 << b, global_interrupt_status);
        chk("source flag", {4'h0, e}, src_flags(b));
        chk("irq masked", 8'h00, {7'h0, irq});
        if (b == 1) chk("mirror off", 8'h01, {7'h0, mirror_driver_disable});
        mcu.rd(GLOBAL_STATUS_OFFSET, d);
        chk("status read", 8'h01 << b, d);
        mcu.wr(GLOBAL_ENABLE_OFFSET, 8'h01 << b);
        cyc(1);
        chk("irq on", 8'h01, {7'h0, irq});
        pulse(b, e, e);
        chk("clear under event", 8'h01 << b, global_interrupt_status);
        pulse(b, 4'h0, e);
        chk("status clear", 8'h00, global_interrupt_status);
        chk("source cleared", 8'h00, src_flags(b));
        chk("irq off", 8'h00, {7'h0, irq});
    endtask

    // Summary must survive direct writes and partial clears
    task automatic multi(int b, logic [3:0] e, logic [3:0] c);
        pulse(b, e, 4'h0);
        mcu.wr(GLOBAL_STATUS_OFFSET, 8'hFF);
        cyc(2);
        chk("direct clear", 8'h01 << b, global_interrupt_status);
        pulse(b, 4'h0, c);
        chk("partial clear", 8'h01 << b, global_interrupt_status);
        pulse(b, 4'h0, e);
        chk("full clear", 8'h00, global_interrupt_status);
    endtask

    task automatic pump_alone;
        pulse(5, 4'b0100, 4'h0);
        chk("pump only", 8'h00, global_interrupt_status);
        pulse(5, 4'h0, 4'b0100);
    endtask

    // Reset in mid-run clears flags, enable and request at once
    task automatic mid_reset;
        mcu.wr(GLOBAL_ENABLE_OFFSET, 8'hFF);
        pulse(0, 4'h1, 4'h0);
        chk("irq before reset", 8'h01, {7'h0, irq});
        rst_n = 1'b0;
        cyc(1);
        chk("status in reset", GLOBAL_STATUS_RESET, global_interrupt_status);
        chk("irq in reset", 8'h00, {7'h0, irq});
        chk("rdata in reset", READ_DATA_RESET, reg_rdata);
        rst_n = 1'b1;
        cyc(1);
        mcu.rd(GLOBAL_ENABLE_OFFSET, d);
        chk("enable after reset", GLOBAL_ENABLE_RESET, d);
    endtask

    task automatic watchdog;
        watchdog_timeout = 1'b1;
        cyc(1);
        watchdog_timeout = 1'b0;
        cyc(2);
        chk("wdt awake", 8'h00, global_interrupt_status);
        standby_mode = 1'b1;
        watchdog_timeout = 1'b1;
        cyc(1);
        watchdog_timeout = 1'b0;
        standby_mode = 1'b0;
        cyc(3);
        chk("wdt standby", 8'h80, global_interrupt_status);
        chk("wdt flag", 8'h01, {7'h0, watchdog_timeout_flag});
        watchdog_clear_bit = ~watchdog_clear_bit;
        cyc(3);
        chk("wdt toggled", 8'h00, global_interrupt_status);
        chk("wdt flag clear", 8'h00, {7'h0, watchdog_timeout_flag});
    endtask

    task automatic summarize;
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // =========================================================
    // Main sequence and watchdog
    initial begin
        repeat (16) @(negedge clk);
        rst_n = 1'b1;
        cyc(1);
        reset_regs;
        for (int b = 0; b < 7; b++) begin
            for (int i = 0; i < widths[b]; i++) begin
                one_source(b, 4'h1 << i);
            end
        end
        pump_alone;
        multi(5, 4'b0101, 4'b0001);
        multi(4, 4'b0011, 4'b0001);
        multi(3, 4'b1001, 4'b0001);
        multi(2, 4'b0110, 4'b0010);
        multi(0, 4'b0110, 4'b0100);
        mid_reset;
        watchdog;
        summarize;
    end

    initial begin
        repeat (20000) @(posedge clk);
        fails++;
        summarize;
    end
endmodule
